//--- design/dma_pkg.sv
// Shared constants, field layouts and carrier types of the DMA controller.
`default_nettype none
package dma_pkg;
    // Number of channels and widths.
    localparam int NUM_CH = 8;
    localparam int CH_W = 3;
    localparam int IRQ_W = 7;
    localparam int NUM_IRQ = 128;
    localparam int CNT_W = 10;
    localparam int ADDR_W = 9;
    // Register index inside a channel; word index = channel * 8 + this.
    localparam logic [2:0] REG_CON = 3'h0;
    localparam logic [2:0] REG_REQ = 3'h1;
    localparam logic [2:0] REG_STA = 3'h2;
    localparam logic [2:0] REG_STB = 3'h3;
    localparam logic [2:0] REG_PAD = 3'h4;
    localparam logic [2:0] REG_CNT = 3'h5;
    // Word indices of the shared status registers.
    localparam logic [6:0] IDX_LAST_ADDR = 7'h40;
    localparam logic [6:0] IDX_COLLISION = 7'h41;
    localparam logic [6:0] IDX_ACTIVITY = 7'h42;
    // Control register field positions and writable mask.
    localparam int CON_ON = 15;
    localparam int CON_SIZE = 14;
    localparam int CON_DIR = 13;
    localparam int CON_HALF = 12;
    localparam int CON_NULL_WRITE_SELECT = 11;
    localparam int CON_ADDRESSING_MODE_FIELD = 4;
    localparam int CON_MODE = 0;
    localparam logic [15:0] CON_MASK = 16'hf833;
    localparam int REQ_FORCE = 15;
    // Addressing and operating mode encodings.
    localparam logic [1:0] ADDRESSING_MODE_FIELD_POSTINC = 2'h0;
    localparam logic [1:0] ADDRESSING_MODE_FIELD_FIXED = 2'h1;
    localparam logic [1:0] ADDRESSING_MODE_FIELD_PERIPH = 2'h2;
    localparam int MODE_ONESHOT = 0;
    localparam int MODE_PINGPONG = 1;
    // Reset values.
    localparam logic [15:0] LAST_ADDR_RST = 16'h0000;
    localparam logic [3:0] LAST_CH_RST = 4'hf;
    localparam logic [15:0] RAM_BASE_DEF = 16'h0000;

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_CAPTURE} xfer_state_t;

    // One access strobe with its address and data.
    typedef struct packed {
        logic re;
        logic we;
        logic byte_sel;
        logic [15:0] addr;
        logic [15:0] wdata;
    } bus_req_t;

    // Per-channel registers and progress.
    typedef struct packed {
        logic [15:0] con;
        logic force_req;
        logic [IRQ_W-1:0] request_source_number;
        logic [15:0] sta;
        logic [15:0] stb;
        logic [15:0] pad;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] idx;
        logic [15:0] latest;
        logic pp;
        logic pending;
    } chan_t;
endpackage
`default_nettype wire

//--- design/dma_priority_pick.sv
// Fixed-priority picker: the lowest numbered pending channel wins.
`default_nettype none
module dma_priority_pick #(
    parameter int N = 8,
    parameter int W = 3
) (
    input wire logic [N-1:0] pend,
    output logic valid,
    output logic [W-1:0] idx
);
    // Scan downward so the last hit, the lowest number, is kept.
    always_comb begin
        valid = |pend;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend[i]) begin
                idx = W'(i);
            end
        end
    end
endmodule // dma_priority_pick
`default_nettype wire

//--- design/dma_controller.sv
// Eight-channel DMA controller with an Avalon-MM register slave.
`default_nettype none
module dma_controller #(
    parameter logic [15:0] RAM_BASE = dma_pkg::RAM_BASE_DEF
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [dma_pkg::ADDR_W-1:0] AV_ADDRESS,
    input wire logic AV_READ,
    input wire logic AV_WRITE,
    input wire logic [31:0] AV_WRITEDATA,
    output logic [31:0] AV_READDATA,
    output logic AV_WAITREQUEST,
    input wire logic [dma_pkg::NUM_IRQ-1:0] IRQ_REQ,
    output dma_pkg::bus_req_t RAM_REQ,
    input wire logic [15:0] RAM_RDATA,
    input wire logic RAM_WCOL,
    output dma_pkg::bus_req_t PER_REQ,
    input wire logic [15:0] PER_RDATA,
    input wire logic [15:0] PER_IND_ADDR,
    input wire logic PER_WCOL,
    output logic [dma_pkg::NUM_CH-1:0] BLOCK_IRQ
);
    typedef struct packed {
        dma_pkg::chan_t [dma_pkg::NUM_CH-1:0] ch;
        dma_pkg::xfer_state_t st;
        logic [dma_pkg::CH_W-1:0] act;
        logic [15:0] last_addr;
        logic [3:0] last_ch;
        logic [dma_pkg::NUM_CH-1:0] ram_coll;
        logic [dma_pkg::NUM_CH-1:0] per_coll;
        logic waitreq;
        logic [31:0] readdata;
        dma_pkg::bus_req_t ram;
        dma_pkg::bus_req_t per;
        logic [dma_pkg::NUM_CH-1:0] blk_irq;
        logic [dma_pkg::NUM_IRQ-1:0] irq_s1;
        logic [dma_pkg::NUM_IRQ-1:0] irq_s2;
        logic [dma_pkg::NUM_IRQ-1:0] irq_s3;
    } state_t;

    state_t s;
    state_t next_s;
    logic [dma_pkg::NUM_CH-1:0] pend;
    logic gnt_valid;
    logic [dma_pkg::CH_W-1:0] gnt;
    dma_pkg::chan_t cur;
    logic blk_end;

    // RAM offset of the element a channel moves next.
    function automatic logic [15:0] elem_offset(input dma_pkg::chan_t c,
            input logic [15:0] ind);
        logic [15:0] base;
        base = c.pp ? c.stb : c.sta;
        case (c.con[dma_pkg::CON_ADDRESSING_MODE_FIELD +: 2])
            dma_pkg::ADDRESSING_MODE_FIELD_POSTINC: elem_offset = base + (c.con[dma_pkg::CON_SIZE]
                ? 16'(c.idx) : {5'h0, c.idx, 1'b0});
            dma_pkg::ADDRESSING_MODE_FIELD_PERIPH: elem_offset = ind;
            default: elem_offset = base;
        endcase
    endfunction

    // Only enabled channels compete for the shared buses.
    always_comb begin
        for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
            pend[i] = s.ch[i].pending && s.ch[i].con[dma_pkg::CON_ON];
        end
    end

    dma_priority_pick #(
        .N(dma_pkg::NUM_CH),
        .W(dma_pkg::CH_W)
    ) u_pick (
        .pend(pend),
        .valid(gnt_valid),
        .idx(gnt)
    );

    assign cur = s.ch[s.act];
    assign blk_end = (s.st == dma_pkg::ST_CAPTURE) && (cur.idx == cur.cnt);

    // Next-state logic: request capture, transfer sequence, then the bus.
    // The bus write comes last so a software set beats a hardware clear.
    always_comb begin
        logic [15:0] off;
        logic [15:0] data;
        logic [15:0] rd;
        logic [6:0] widx;
        logic [2:0] wch;
        logic [dma_pkg::NUM_CH-1:0] edge_hit;
        edge_hit = '0;
        off = '0;
        data = '0;
        rd = '0;
        widx = AV_ADDRESS[dma_pkg::ADDR_W-1:2];
        wch = widx[5:3];
        next_s = s;
        next_s.irq_s1 = IRQ_REQ;
        next_s.irq_s2 = s.irq_s1;
        next_s.irq_s3 = s.irq_s2;
        next_s.ram.re = 1'b0;
        next_s.ram.we = 1'b0;
        next_s.per.re = 1'b0;
        next_s.per.we = 1'b0;
        next_s.blk_irq = '0;

        // A rising request edge or a forced transfer makes a channel pending.
        // A force counts only while no element of its channel is in flight,
        // or one force would be served twice before its bit drops.
        for (int i = 0; i < dma_pkg::NUM_CH; i++) begin
            edge_hit[i] = s.irq_s2[s.ch[i].request_source_number] &&
                !s.irq_s3[s.ch[i].request_source_number];
            if (s.ch[i].con[dma_pkg::CON_ON] && (edge_hit[i] ||
                    (s.ch[i].force_req &&
                    !(s.st != dma_pkg::ST_IDLE && s.act == 3'(i))))) begin
                next_s.ch[i].pending = 1'b1;
            end
        end

        // Collisions are charged to the channel that owns the buses.
        if (RAM_WCOL) begin
            next_s.ram_coll[s.act] = 1'b1;
        end
        if (PER_WCOL) begin
            next_s.per_coll[s.act] = 1'b1;
        end

        // Each element takes three cycles: issue read, wait, write back.
        case (s.st)
            dma_pkg::ST_IDLE: begin
                if (gnt_valid) begin
                    off = elem_offset(s.ch[gnt], PER_IND_ADDR);
                    next_s.act = gnt;
                    next_s.last_ch = {1'b0, gnt};
                    // A fresh request edge in the grant cycle stays pending.
                    next_s.ch[gnt].pending = edge_hit[gnt];
                    next_s.ch[gnt].latest = off;
                    next_s.last_addr = RAM_BASE + off;
                    if (s.ch[gnt].con[dma_pkg::CON_DIR]) begin
                        next_s.ram.re = 1'b1;
                        next_s.ram.addr = RAM_BASE + off;
                        next_s.ram.byte_sel = s.ch[gnt].con[dma_pkg::CON_SIZE];
                    end else begin
                        next_s.per.re = 1'b1;
                        next_s.per.addr = s.ch[gnt].pad;
                        next_s.per.byte_sel = s.ch[gnt].con[dma_pkg::CON_SIZE];
                    end
                    next_s.st = dma_pkg::ST_READ;
                end
            end
            dma_pkg::ST_READ: begin
                next_s.st = dma_pkg::ST_CAPTURE;
            end
            dma_pkg::ST_CAPTURE: begin
                data = cur.con[dma_pkg::CON_DIR] ? RAM_RDATA : PER_RDATA;
                if (cur.con[dma_pkg::CON_DIR]) begin
                    next_s.per.we = 1'b1;
                    next_s.per.addr = cur.pad;
                    next_s.per.wdata = data;
                    next_s.per.byte_sel = cur.con[dma_pkg::CON_SIZE];
                end else begin
                    next_s.ram.we = 1'b1;
                    next_s.ram.addr = s.last_addr;
                    next_s.ram.wdata = data;
                    next_s.ram.byte_sel = cur.con[dma_pkg::CON_SIZE];
                    // Null write pokes the peripheral with zero as well.
                    if (cur.con[dma_pkg::CON_NULL_WRITE_SELECT]) begin
                        next_s.per.we = 1'b1;
                        next_s.per.addr = cur.pad;
                        next_s.per.wdata = '0;
                        next_s.per.byte_sel = cur.con[dma_pkg::CON_SIZE];
                    end
                end
                next_s.ch[s.act].force_req = 1'b0;
                if (cur.con[dma_pkg::CON_HALF] && cur.idx == (cur.cnt >> 1)) begin
                    next_s.blk_irq[s.act] = 1'b1;
                end
                if (blk_end) begin
                    next_s.ch[s.act].idx = '0;
                    if (!cur.con[dma_pkg::CON_HALF]) begin
                        next_s.blk_irq[s.act] = 1'b1;
                    end
                    if (cur.con[dma_pkg::CON_MODE + dma_pkg::MODE_PINGPONG]) begin
                        next_s.ch[s.act].pp = !cur.pp;
                    end
                    // One-shot ping-pong stops once both buffers are done.
                    if (cur.con[dma_pkg::CON_MODE + dma_pkg::MODE_ONESHOT] &&
                            (!cur.con[dma_pkg::CON_MODE + dma_pkg::MODE_PINGPONG]
                            || cur.pp)) begin
                        next_s.ch[s.act].con[dma_pkg::CON_ON] = 1'b0;
                    end
                end else begin
                    next_s.ch[s.act].idx = cur.idx + 10'h001;
                end
                next_s.st = dma_pkg::ST_IDLE;
            end
            default: begin
                next_s.st = dma_pkg::ST_IDLE;
            end
        endcase

        // Register read multiplexer; unmapped words read as zero.
        if (widx[6] == 1'b0) begin
            case (widx[2:0])
                dma_pkg::REG_CON: rd = s.ch[wch].con;
                dma_pkg::REG_REQ: rd = {s.ch[wch].force_req, 8'h00,
                    s.ch[wch].request_source_number};
                dma_pkg::REG_STA: rd = s.ch[wch].latest;
                dma_pkg::REG_STB: rd = s.ch[wch].latest;
                dma_pkg::REG_PAD: rd = s.ch[wch].pad;
                dma_pkg::REG_CNT: rd = {6'h00, s.ch[wch].cnt};
                default: rd = '0;
            endcase
        end else begin
            case (widx)
                dma_pkg::IDX_LAST_ADDR: rd = s.last_addr;
                dma_pkg::IDX_COLLISION: rd = {s.per_coll, s.ram_coll};
                dma_pkg::IDX_ACTIVITY: rd = {4'h0, s.last_ch,
                    s.ch[7].pp, s.ch[6].pp, s.ch[5].pp, s.ch[4].pp,
                    s.ch[3].pp, s.ch[2].pp, s.ch[1].pp, s.ch[0].pp};
                default: rd = '0;
            endcase
        end

        // Every access is answered one cycle after it is first seen.
        next_s.waitreq = 1'b1;
        if ((AV_READ || AV_WRITE) && s.waitreq) begin
            next_s.waitreq = 1'b0;
            next_s.readdata = {16'h0000, rd};
        end

        // A write lands at the edge where waitrequest is seen low.
        // Offsets, address and count are not guarded while enabled.
        if (AV_WRITE && !s.waitreq && widx[6] == 1'b0) begin
            case (widx[2:0])
                dma_pkg::REG_CON: begin
                    next_s.ch[wch].con = AV_WRITEDATA[15:0] & dma_pkg::CON_MASK;
                    if (!s.ch[wch].con[dma_pkg::CON_ON] &&
                            AV_WRITEDATA[dma_pkg::CON_ON]) begin
                        next_s.ch[wch].idx = '0;
                        next_s.ch[wch].pp = 1'b0;
                        next_s.ch[wch].pending = 1'b0;
                    end
                end
                dma_pkg::REG_REQ: begin
                    next_s.ch[wch].request_source_number = AV_WRITEDATA[dma_pkg::IRQ_W-1:0];
                    if (AV_WRITEDATA[dma_pkg::REQ_FORCE]) begin
                        next_s.ch[wch].force_req = 1'b1;
                    end
                end
                dma_pkg::REG_STA: next_s.ch[wch].sta = AV_WRITEDATA[15:0];
                dma_pkg::REG_STB: next_s.ch[wch].stb = AV_WRITEDATA[15:0];
                dma_pkg::REG_PAD: next_s.ch[wch].pad = AV_WRITEDATA[15:0];
                dma_pkg::REG_CNT: next_s.ch[wch].cnt =
                    AV_WRITEDATA[dma_pkg::CNT_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // State register for all eight channels and the shared status.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            s <= '0;
            s.waitreq <= 1'b1;
            s.last_addr <= dma_pkg::LAST_ADDR_RST;
            s.last_ch <= dma_pkg::LAST_CH_RST;
        end else begin
            s <= next_s;
        end
    end

    assign AV_READDATA = s.readdata;
    assign AV_WAITREQUEST = s.waitreq;
    assign RAM_REQ = s.ram;
    assign PER_REQ = s.per;
    assign BLOCK_IRQ = s.blk_irq;

    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    chk_prio_lowest: assert property (gnt_valid |->
        (pend & ((8'h01 << gnt) - 8'h01)) == 8'h00)
        else $error("Granted channel is not the lowest pending one.");
    chk_grant_taken: assert property ((s.st == dma_pkg::ST_IDLE && gnt_valid)
        |=> s.act == $past(gnt) && s.st == dma_pkg::ST_READ)
        else $error("Winning channel did not start its transfer.");
    chk_read_side: assert property ((s.st == dma_pkg::ST_READ) |->
        s.ram.re == cur.con[dma_pkg::CON_DIR] &&
        s.per.re == !cur.con[dma_pkg::CON_DIR])
        else $error("Read issued on the wrong side for the direction.");
    chk_element_cycle: assert property ((s.st == dma_pkg::ST_READ) |=>
        ##1 !s.ram.re && !s.per.re && (cur.con[dma_pkg::CON_DIR] ? s.per.we
        : s.ram.we))
        else $error("Write-back did not follow the read two cycles later.");
    chk_full_irq: assert property ((blk_end && !cur.con[dma_pkg::CON_HALF])
        |=> BLOCK_IRQ == (8'h01 << $past(s.act)))
        else $error("Full-block interrupt missing at count plus one.");
    chk_block_wrap: assert property (blk_end |=>
        s.ch[$past(s.act)].idx == 10'h000)
        else $error("Element index did not return to zero after a block.");
    chk_pp_swap: assert property ((blk_end &&
        cur.con[dma_pkg::CON_MODE + dma_pkg::MODE_PINGPONG]) |=>
        s.ch[$past(s.act)].pp != $past(cur.pp))
        else $error("Ping-pong select did not swap after a block.");
    chk_force_drop: assert property ((s.st == dma_pkg::ST_CAPTURE &&
        !AV_WRITE) |=> !s.ch[$past(s.act)].force_req)
        else $error("Force bit survived its transfer.");
    chk_last_addr: assert property ((s.st == dma_pkg::ST_READ) |->
        s.last_addr == RAM_BASE + cur.latest)
        else $error("Last address does not match the channel offset.");
    chk_bus_answer: assert property (((AV_READ || AV_WRITE) && s.waitreq)
        |=> !AV_WAITREQUEST ##1 AV_WAITREQUEST)
        else $error("Bus access not answered in exactly one cycle.");

    cov_block_done: cover property (blk_end ##1 BLOCK_IRQ != 8'h00);
    cov_pp_swap: cover property (blk_end && cur.pp);
    cov_two_pending: cover property ($countones(pend) >= 2);
    cov_forced: cover property (s.st == dma_pkg::ST_CAPTURE && cur.force_req);
endmodule // dma_controller
`default_nettype wire

//--- test/mem_periph_model.sv
// Behavioural RAM and peripheral data source facing the DMA controller.
`default_nettype none
module mem_periph_model (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire dma_pkg::bus_req_t RAM_REQ,
    input wire dma_pkg::bus_req_t PER_REQ,
    output logic [15:0] RAM_RDATA,
    output logic [15:0] PER_RDATA
);
    timeunit 1ns;
    timeprecision 1ns;
    // Read data stand only in the cycle after a read strobe; otherwise the
    // lines toggle, so a sample taken at the wrong edge cannot match by luck.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            RAM_RDATA <= 16'h0000;
            PER_RDATA <= 16'h0000;
        end else begin
            RAM_RDATA <= RAM_REQ.re ? (RAM_REQ.addr ^ 16'h5a00) : ~RAM_RDATA;
            PER_RDATA <= PER_REQ.re ? (PER_REQ.addr ^ 16'ha500) : ~PER_RDATA;
        end
    end
endmodule // mem_periph_model
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench: registers, forced and requested transfers, priority.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [8:0] av_address = 9'h000;
    logic av_read = 1'b0;
    logic av_write = 1'b0;
    logic [31:0] av_writedata = 32'h00000000;
    logic [31:0] av_readdata;
    logic av_waitrequest;
    logic [127:0] irq_req = 128'h0;
    logic ram_wcol = 1'b0;
    logic per_wcol = 1'b0;
    logic [15:0] per_ind_addr = 16'h0000;
    dma_pkg::bus_req_t ram_req, per_req;
    logic [15:0] ram_rdata, per_rdata;
    logic [7:0] block_irq;
    logic [15:0] q_rre[$], q_pre[$];
    logic [31:0] q_rwe[$], q_pwe[$];
    int irq_n[8];
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic [15:0] pp_addr[4] = '{16'h0050, 16'h0051, 16'h0060, 16'h0061};

    dma_controller u_dut (.CLK(clk), .SYS_RST(sys_rst),
        .AV_ADDRESS(av_address), .AV_READ(av_read), .AV_WRITE(av_write),
        .AV_WRITEDATA(av_writedata), .AV_READDATA(av_readdata),
        .AV_WAITREQUEST(av_waitrequest), .IRQ_REQ(irq_req),
        .RAM_REQ(ram_req), .RAM_RDATA(ram_rdata), .RAM_WCOL(ram_wcol),
        .PER_REQ(per_req), .PER_RDATA(per_rdata),
        .PER_IND_ADDR(per_ind_addr), .PER_WCOL(per_wcol),
        .BLOCK_IRQ(block_irq));
    mem_periph_model u_far (.CLK(clk), .SYS_RST(sys_rst), .RAM_REQ(ram_req),
        .PER_REQ(per_req), .RAM_RDATA(ram_rdata), .PER_RDATA(per_rdata));

    // Free-running clock at 8 ns.
    initial begin
        forever #4 clk = ~clk;
    end

    // Record every strobe so that order and content can be compared later.
    always @(posedge clk) begin
        cycles++;
        if (ram_req.re === 1'b1) q_rre.push_back(ram_req.addr);
        if (per_req.re === 1'b1) q_pre.push_back(per_req.addr);
        if (ram_req.we === 1'b1) q_rwe.push_back({ram_req.addr, ram_req.wdata});
        if (per_req.we === 1'b1) q_pwe.push_back({per_req.addr, per_req.wdata});
        for (int i = 0; i < 8; i++) begin
            if (block_irq[i] === 1'b1) irq_n[i]++;
        end
        if (cycles > 20000) begin
            failures++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Holds the request until waitrequest is sampled low, then one idle edge.
    task automatic av_xfer(input logic wr, input logic [8:0] a,
                           input logic [15:0] d, output logic [31:0] q);
        int n;
        n = 0;
        av_address <= a;
        av_writedata <= {16'h0000, d};
        av_write <= wr;
        av_read <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (av_waitrequest !== 1'b0 && n < 50);
        q = av_readdata;
        if (n >= 50) failures++;
        av_write <= 1'b0;
        av_read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic av_wr(input logic [8:0] a, input logic [15:0] d);
        av_xfer(1'b1, a, d, rd);
    endtask

    task automatic av_rd(input logic [8:0] a, output logic [31:0] q);
        av_xfer(1'b0, a, 16'h0000, q);
    endtask

    // Channel set-up writes start address A, peripheral address, count and request first, and the control word last.
    task automatic cfg(input int ch, input logic [15:0] con,
                       input logic [15:0] req, input logic [15:0] sta,
                       input logic [15:0] pad, input logic [15:0] cnt);
        logic [8:0] b;
        b = 9'(ch * 32);
        av_wr(b + 9'h008, sta);
        av_wr(b + 9'h010, pad);
        av_wr(b + 9'h014, cnt);
        av_wr(b + 9'h004, req);
        av_wr(b, con);
    endtask

    // Forces one element and polls until hardware drops the force bit.
    task automatic kick(input logic [8:0] a, input logic [15:0] req);
        av_wr(a, req | 16'h8000);
        for (int n = 0; n < 20; n++) begin
            av_rd(a, rd);
            if (rd[15] === 1'b0) break;
        end
        chk(rd, {16'h0000, req});
    endtask

    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        // Reset values, read-only and unmapped places.
        av_rd(9'h100, rd); chk(rd, 32'h0);
        av_rd(9'h108, rd); chk(rd, 32'h00000f00);
        av_rd(9'h104, rd); chk(rd, 32'h0);
        av_wr(9'h100, 16'hffff);
        av_rd(9'h100, rd); chk(rd, 32'h0);
        av_rd(9'h1fc, rd); chk(rd, 32'h0);
        av_wr(9'h0e0, 16'h7fff);
        av_rd(9'h0e0, rd); chk(rd, 32'h00007833);
        av_rd(9'h0f0, rd); chk(rd, 32'h0);
        av_wr(9'h0f0, 16'hbeef);
        av_rd(9'h0f0, rd); chk(rd, 32'h0000beef);
        // Three forced elements, RAM to peripheral, one-shot, count two.
        cfg(0, 16'ha001, 16'h007f, 16'h0010, 16'h0080, 16'h0002);
        for (int i = 0; i < 3; i++) begin
            kick(9'h004, 16'h007f);
            repeat (4) @(posedge clk);
            chk(irq_n[0], (i == 2) ? 1 : 0);
        end
        for (int i = 0; i < 3; i++) begin
            chk(q_rre[i], 32'(16'h0010 + 16'(2 * i)));
            chk(q_pwe[i], {16'h0080, 16'h5a10 + 16'(2 * i)});
        end
        chk(q_rre.size(), 3);
        av_rd(9'h100, rd); chk(rd, 32'h00000014);
        av_rd(9'h008, rd); chk(rd, 32'h00000014);
        av_rd(9'h108, rd); chk(rd, 32'h0);
        // Two channels requested at once by peripheral lines 5 and 6.
        q_pre.delete();
        q_rwe.delete();
        cfg(1, 16'h8011, 16'h0005, 16'h0020, 16'h0041, 16'h0000);
        cfg(2, 16'h8010, 16'h0006, 16'h0030, 16'h0042, 16'h0000);
        irq_req[6:5] <= 2'b11;
        for (int n = 0; n < 100 && irq_n[2] == 0; n++) @(posedge clk);
        chk(q_pre[0], 32'h00000041);
        chk(q_pre[1], 32'h00000042);
        chk(q_rwe[0], {16'h0020, 16'ha541});
        chk(q_rwe[1], {16'h0030, 16'ha542});
        chk(irq_n[1], 1);
        av_rd(9'h100, rd); chk(rd, 32'h00000030);
        av_rd(9'h108, rd); chk(rd, 32'h00000200);
        av_rd(9'h040, rd); chk(rd, 32'h00008010);
        // Byte size, half-block interrupt, null write, one-shot ping-pong.
        q_pre.delete();
        q_rwe.delete();
        q_pwe.delete();
        av_wr(9'h06c, 16'h0060);
        cfg(3, 16'hd803, 16'h007f, 16'h0050, 16'h0044, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            kick(9'h064, 16'h007f);
            if (i == 1) begin
                av_rd(9'h108, rd); chk(rd, 32'h00000308);
            end
        end
        for (int i = 0; i < 4; i++) begin
            chk(q_rwe[i], {pp_addr[i], 16'ha544});
            chk(q_pwe[i], {16'h0044, 16'h0000});
        end
        chk(q_pre.size(), 4);
        chk(irq_n[3], 2);
        av_rd(9'h06c, rd); chk(rd, 32'h00000061);
        av_rd(9'h060, rd); chk(rd, 32'h00005803);
        // Peripheral-indirect RAM address, then one collision of each kind.
        q_rre.delete();
        q_pwe.delete();
        per_ind_addr <= 16'h0077;
        cfg(4, 16'ha021, 16'h007f, 16'h0000, 16'h0090, 16'h0000);
        kick(9'h084, 16'h007f);
        chk(q_rre[0], 32'h00000077);
        chk(q_pwe[0], {16'h0090, 16'h5a77});
        ram_wcol <= 1'b1;
        per_wcol <= 1'b1;
        @(posedge clk);
        ram_wcol <= 1'b0;
        per_wcol <= 1'b0;
        @(posedge clk);
        av_rd(9'h104, rd); chk(rd, 32'h00001010);
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
